// ### rtl/mrrs_pkg.sv
// Package: constants and carriers for the multi-rail reset supervisor
package mrrs_pkg;
  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned HOLD_MS        = 140;
  localparam int unsigned HOLD_CYC       = (CLK_HZ / 1000) * HOLD_MS;
  localparam int unsigned WDOG_MS        = 1600;
  localparam int unsigned WDOG_CYC       = (CLK_HZ / 1000) * WDOG_MS;
  localparam int unsigned MDLY_US        = 100;
  localparam int unsigned MDLY_CYC       = (CLK_HZ / 1000000) * MDLY_US;
  localparam int unsigned DEB_US         = 1000;
  localparam int unsigned DEB_CYC        = (CLK_HZ / 1000000) * DEB_US;
  // Adjustable-input thresholds in millivolts, per band
  localparam logic [9:0]  ADJ_TH_MV_NARROW = 10'h18a; // 394
  localparam logic [9:0]  ADJ_TH_MV_WIDE   = 10'h175; // 373
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ    = 12'h008;
  localparam logic [11:0] ADDR_MASK   = 12'h00c;
  localparam logic [11:0] ADDR_HOLD   = 12'h010;
  localparam int unsigned IRQ_RESET   = 0;
  localparam int unsigned IRQ_WDOG    = 1;
  localparam int unsigned IRQ_RAIL    = 2;
  localparam int unsigned IRQ_W       = 3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_HOLD = 3'h1,
    ST_TIME = 3'h2,
    ST_RUN  = 3'h4
  } mrrs_state_e;

  typedef struct packed {
    logic lockout;
    logic manual;
    logic margin_n;
    logic band;
    logic ext_timeout;
    logic wd_present;
    logic wd_kick;
  } mrrs_pins_s;
endpackage

// ### rtl/mrrs_top.sv
// Supervisor core: rail status, reset sequencing, watchdog, register slave
// How it works
// (R01) Band select picks 5% or 10% thresholds
// (R02) Adjustable threshold 394mV narrow, 373mV wide
// (R03) Each status low while its rail low
// (R04) Reset asserts on any low rail, manual
// (R05) Reset held full timeout after causes clear
// (R06) Fixed timeout at least 140ms when tied
// (R07) External timing element sets timeout instead
// (R08) Manual reset holds reset, then 140ms
// (R09) Open manual input reads as inactive high
// (R10) Bouncing manual switch filtered internally
// (R11) Margin low forces outputs high, frozen
// (R12) Watchdog runs in margin, reset after delay
// (R13) Open margin input reads as inactive
// (R14) Supply lockout asserts reset, statuses low
// (R15) Power-up holds outputs until lockout clears
// (R16) Unused rails held above threshold externally
// (R17) Watchdog silence past 1.6s asserts reset
// (R18) Absent watchdog input disables watchdog
// (R19) Reappearing cause restarts full timeout
module mrrs_top #(
  parameter int unsigned NUM_RAILS = 8,
  parameter int unsigned HOLD_CYC  = mrrs_pkg::HOLD_CYC,
  parameter int unsigned WDOG_CYC  = mrrs_pkg::WDOG_CYC,
  parameter int unsigned MDLY_CYC  = mrrs_pkg::MDLY_CYC,
  parameter int unsigned DEB_CYC   = mrrs_pkg::DEB_CYC
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [NUM_RAILS-1:0] rail_under,
  input  wire logic                 supply_lockout,
  input  wire logic                 manual_reset_n,
  input  wire logic                 margin_n,
  input  wire logic                 threshold_band_select,
  input  wire logic                 timeout_set_pin,
  input  wire logic                 ext_timeout_done,
  input  wire logic                 watchdog_present,
  input  wire logic                 watchdog_kick_input,
  output logic      [NUM_RAILS-1:0] rail_ok,
  output logic                      sys_reset_n,
  output logic                      threshold_band_wide,
  output logic      [9:0]           adj_threshold_mv,
  output logic                      irq,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic      [1:0]           s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic      [31:0]          s_axi_rdata,
  output logic      [1:0]           s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  localparam int unsigned IW = mrrs_pkg::IRQ_W;

  // Two-flop synchronisers for all pins except the external timing element done flag
  localparam int unsigned SW = NUM_RAILS + 7;
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  wire  [SW-1:0] pin_raw = {rail_under, supply_lockout, manual_reset_n,
                            margin_n, threshold_band_select,
                            timeout_set_pin, watchdog_present,
                            watchdog_kick_input};
  // Open pins read inactive; lockout starts set so outputs stay low
  localparam mrrs_pkg::mrrs_pins_s PINS_RST = '{lockout: 1'b1, manual: 1'b1,
    margin_n: 1'b1, default: 1'b0}; // (R09) (R13) (R15)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {{NUM_RAILS{1'b0}}, PINS_RST};
      sync_q <= {{NUM_RAILS{1'b0}}, PINS_RST};
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end
  mrrs_pkg::mrrs_pins_s pins;
  wire [NUM_RAILS-1:0] under_s = sync_q[SW-1:7];
  assign pins = mrrs_pkg::mrrs_pins_s'(sync_q[6:0]);

  // Pull-ups: open manual and margin pins sit inactive high
  wire manual_n_s = pins.manual; // (R09)
  wire margin_on  = !pins.margin_n; // (R13)
  assign threshold_band_wide = pins.band; // (R01)
  assign adj_threshold_mv = pins.band ? mrrs_pkg::ADJ_TH_MV_WIDE
                                      : mrrs_pkg::ADJ_TH_MV_NARROW; // (R02)

  // Manual debounce: input must sit stable before it counts
  logic        man_q, man_prev_q, ext_q, ext_m_q;
  logic [31:0] deb_q;
  wire deb_done = (deb_q >= DEB_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      man_q      <= 1'b1;
      man_prev_q <= 1'b1;
      deb_q      <= '0;
    end else begin
      man_prev_q <= manual_n_s;
      if (manual_n_s != man_prev_q) deb_q <= '0; // (R10)
      else if (!deb_done) deb_q <= deb_q + 32'h1;
      else man_q <= man_prev_q; // (R10)
    end
  end
  // External timing element done flag also crosses from a pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_m_q <= 1'b0;
      ext_q   <= 1'b0;
    end else begin
      ext_m_q <= ext_timeout_done;
      ext_q   <= ext_m_q;
    end
  end

  // Watchdog: count idle time, restart on each kick edge
  logic        kick_prev_q, wd_fire_q, wd_pend_q, margin_prev_q;
  logic [31:0] wd_q, md_q;
  wire kick_edge = pins.wd_kick != kick_prev_q;
  wire wd_on     = pins.wd_present && !pins.lockout; // (R18)
  wire wd_expire = wd_on && (wd_q >= WDOG_CYC - 1);
  wire margin_rel = margin_prev_q && !margin_on;
  wire md_done   = (md_q >= MDLY_CYC - 1);
  logic        st_hold;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kick_prev_q   <= 1'b0;
      wd_q          <= '0;
      wd_pend_q     <= 1'b0;
      wd_fire_q     <= 1'b0;
      margin_prev_q <= 1'b0;
      md_q          <= '0;
    end else begin
      kick_prev_q   <= pins.wd_kick;
      margin_prev_q <= margin_on;
      wd_fire_q     <= 1'b0;
      // Margin keeps the count running even while reset is held inside
      if (!wd_on || kick_edge || (st_hold && !margin_on))
        wd_q <= '0; // (R12)
      else if (!wd_expire) wd_q <= wd_q + 32'h1; // (R17)
      if (wd_expire && margin_on) wd_pend_q <= 1'b1; // (R12)
      else if (wd_expire && !wd_pend_q) wd_fire_q <= 1'b1; // (R17)
      if (margin_rel && wd_pend_q) md_q <= 32'h1;
      else if (md_q != 0 && !md_done) md_q <= md_q + 32'h1;
      else if (md_q != 0) begin
        md_q      <= '0;
        wd_pend_q <= 1'b0;
        wd_fire_q <= 1'b1; // (R12)
      end
    end
  end

  // Reset sequencer
  mrrs_pkg::mrrs_state_e st_q, st_d;
  logic [31:0] hold_q;
  wire any_under = |under_s;
  wire cause = pins.lockout || any_under || !man_q || wd_fire_q; // (R04)
  wire hold_end = pins.ext_timeout ? (hold_q >= HOLD_CYC - 1)
                                   : ext_q; // (R06) (R07)
  assign st_hold = (st_q != mrrs_pkg::ST_RUN);
  // Count only while staying in the timing state, so any exit zeroes it
  wire hold_run = (st_q == mrrs_pkg::ST_TIME) &&
                  (st_d == mrrs_pkg::ST_TIME);
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      mrrs_pkg::ST_HOLD: if (!cause) st_d = mrrs_pkg::ST_TIME; // (R05)
      mrrs_pkg::ST_TIME: begin
        if (cause) st_d = mrrs_pkg::ST_HOLD; // (R19)
        else if (hold_end) st_d = mrrs_pkg::ST_RUN; // (R05) (R08)
      end
      mrrs_pkg::ST_RUN:  if (cause) st_d = mrrs_pkg::ST_HOLD; // (R04)
      default:           st_d = mrrs_pkg::ST_HOLD;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= mrrs_pkg::ST_HOLD;
      hold_q <= '0;
    end else begin
      st_q   <= st_d;
      hold_q <= hold_run ? hold_q + 32'h1 : '0; // (R19)
    end
  end

  // Outputs: margin freezes them high; lockout forces low
  wire [NUM_RAILS-1:0] ok_d = pins.lockout ? '0 : ~under_s; // (R03) (R14)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rail_ok     <= '0; // (R15)
      sys_reset_n <= 1'b0; // (R15)
    end else if (margin_on && !pins.lockout) begin
      rail_ok     <= '1; // (R11)
      sys_reset_n <= 1'b1; // (R11)
    end else begin
      rail_ok     <= ok_d; // (R03)
      sys_reset_n <= (st_d == mrrs_pkg::ST_RUN); // (R04) (R14)
    end
  end

  // Event flags, set wins over clear
  logic [IW-1:0] ev, irq_q, mask_q;
  logic          rst_prev_q;
  logic [NUM_RAILS-1:0] ok_prev_q;
  assign ev[mrrs_pkg::IRQ_RESET] = rst_prev_q && !sys_reset_n;
  assign ev[mrrs_pkg::IRQ_WDOG]  = wd_fire_q;
  assign ev[mrrs_pkg::IRQ_RAIL]  = |(ok_prev_q & ~rail_ok);
  assign irq = |(irq_q & mask_q);

  // AXI4-Lite slave: one write and one read at a time
  logic          aw_q, w_q;
  logic [11:0]   awa_q;
  logic [31:0]   wd_r_q;
  wire wr_go  = aw_q && w_q && !s_axi_bvalid;
  wire wr_irq = wr_go && (awa_q == mrrs_pkg::ADDR_IRQ);
  wire wr_msk = wr_go && (awa_q == mrrs_pkg::ADDR_MASK);
  wire wr_ok  = (awa_q == mrrs_pkg::ADDR_IRQ) ||
                (awa_q == mrrs_pkg::ADDR_MASK);
  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_arready = !s_axi_rvalid;
  wire [IW-1:0] clr = wr_irq ? wd_r_q[IW-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= '0;
      wd_r_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mrrs_pkg::RESP_OKAY;
      irq_q <= '0;
      mask_q <= '0;
      rst_prev_q <= 1'b0;
      ok_prev_q <= '0;
    end else begin
      rst_prev_q <= sys_reset_n;
      ok_prev_q  <= rail_ok;
      irq_q <= (irq_q & ~clr) | ev; // Set wins over clear
      if (s_axi_awvalid && !aw_q) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q    <= 1'b1;
        wd_r_q <= s_axi_wdata;
      end
      if (wr_msk) mask_q <= wd_r_q[IW-1:0];
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? mrrs_pkg::RESP_OKAY : mrrs_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  logic [31:0] rd_d;
  logic        rd_ok;
  always_comb begin
    rd_d  = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      mrrs_pkg::ADDR_CTRL:   rd_d = 32'(sync_q[6:0]);
      mrrs_pkg::ADDR_STATUS: rd_d = {10'h0, 5'(st_q), 1'(sys_reset_n),
                                     16'(rail_ok)};
      mrrs_pkg::ADDR_IRQ:    rd_d = 32'(irq_q);
      mrrs_pkg::ADDR_MASK:   rd_d = 32'(mask_q);
      mrrs_pkg::ADDR_HOLD:   rd_d = hold_q;
      default:               rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= mrrs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= rd_ok ? mrrs_pkg::RESP_OKAY : mrrs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end

  // Checks
  a_lockout_low: assert property (@(posedge aclk) disable iff (!aresetn)
    pins.lockout |=> (rail_ok == '0) && !sys_reset_n)
    else $error("lockout did not force outputs low"); // (R14)
  a_margin_high: assert property (@(posedge aclk) disable iff (!aresetn)
    margin_on && !pins.lockout |=> sys_reset_n && (&rail_ok))
    else $error("margin did not force outputs high"); // (R11)
  a_rail_track: assert property (@(posedge aclk) disable iff (!aresetn)
    !margin_on && !pins.lockout |=> rail_ok == ~$past(under_s))
    else $error("rail status mismatch"); // (R03)
  a_cause_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    cause && !margin_on |=> !sys_reset_n)
    else $error("reset missing while cause present"); // (R04)
  a_hold_min: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sys_reset_n) && !margin_on && pins.ext_timeout
    |-> $past(hold_q) >= HOLD_CYC - 1)
    else $error("reset released early"); // (R05)
  a_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == mrrs_pkg::ST_TIME && cause |=> hold_q == 0)
    else $error("timeout not restarted"); // (R19)
  a_wd_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !wd_on && !wd_pend_q |=> !wd_fire_q)
    else $error("watchdog fired while off"); // (R18)
  a_wd_margin: assert property (@(posedge aclk) disable iff (!aresetn)
    wd_expire && margin_on |=> wd_pend_q)
    else $error("margin expiry not kept pending"); // (R12)
  a_man_filter: assert property (@(posedge aclk) disable iff (!aresetn)
    manual_n_s != man_prev_q |=> man_q == $past(man_q))
    else $error("manual input passed while bouncing"); // (R10)
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  a_band_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    adj_threshold_mv == (threshold_band_wide ? 10'h175 : 10'h18a))
    else $error("band threshold wrong"); // (R02)
  c_margin: cover property (@(posedge aclk) margin_rel && wd_pend_q);
  c_release: cover property (@(posedge aclk) $rose(sys_reset_n));
  c_wdog: cover property (@(posedge aclk) wd_fire_q && !margin_on);
  c_restart: cover property (@(posedge aclk)
    st_q == mrrs_pkg::ST_TIME && cause);
  c_ext_end: cover property (@(posedge aclk)
    !pins.ext_timeout && $rose(sys_reset_n));
endmodule // mrrs_top

// ### verif/mrrs_partner.sv
// Far-side model: supply rails and a processor that services the watchdog
module mrrs_partner #(
  parameter int unsigned NUM_RAILS = 8
) (
  input  wire logic                 aclk,
  input  wire logic                 sys_reset_n,
  input  wire logic                 kick_en,
  input  wire logic [NUM_RAILS-1:0] drop,
  output logic      [NUM_RAILS-1:0] rail_under,
  output logic                      kick
);
  logic [3:0] tick_q = 4'h0;
  // Rails not dropped on purpose sit above threshold
  assign rail_under = drop;
  initial kick = 1'b0;
  // Processor only services the watchdog while it is out of reset
  always @(posedge aclk) begin
    tick_q <= tick_q + 4'h1;
    if (kick_en && sys_reset_n && tick_q == 4'hf) begin
      kick <= ~kick;
    end
  end
endmodule // mrrs_partner

// ### verif/mrrs_top_tb_top.sv
// Testbench: pin scenarios and register accesses for the supervisor
module mrrs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 50;
  localparam int W = 200;
  localparam int M = 5;
  logic        aclk, aresetn, lockout, mrn, margin_n, band, tsp, ext_done;
  logic        wd_present, kick, kick_en, irq, sys_reset_n, wide;
  logic [7:0]  drop, rail_under, rail_ok;
  logic [9:0]  adj_mv;
  logic [11:0] awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  int          fails, compares, n;

  mrrs_top #(.NUM_RAILS(8), .HOLD_CYC(H), .WDOG_CYC(W), .MDLY_CYC(M),
    .DEB_CYC(4)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .rail_under(rail_under),
    .supply_lockout(lockout), .manual_reset_n(mrn), .margin_n(margin_n),
    .threshold_band_select(band), .timeout_set_pin(tsp),
    .ext_timeout_done(ext_done), .watchdog_present(wd_present),
    .watchdog_kick_input(kick), .rail_ok(rail_ok),
    .sys_reset_n(sys_reset_n), .threshold_band_wide(wide),
    .adj_threshold_mv(adj_mv), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  mrrs_partner #(.NUM_RAILS(8)) u_far (.aclk(aclk),
    .sys_reset_n(sys_reset_n), .kick_en(kick_en), .drop(drop),
    .rail_under(rail_under), .kick(kick));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic conclude;
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // Counts edges until the reset output shows v, giving up at lim
  task automatic wt(input logic v, input int lim);
    n = 0;
    while (sys_reset_n !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // Reset output must reach v no sooner than lo edges, within hi
  task automatic ex(input logic v, input int lo, input int hi);
    wt(v, hi);
    chk("sys_reset_n", {31'h0, v}, {31'h0, n >= lo ? sys_reset_n : ~v});
  endtask

  task automatic stay(input int lim);
    wt(1'b0, lim);
    chk("sys_reset_n", 32'h1, {31'h0, sys_reset_n});
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  initial begin
    repeat (9000) @(posedge aclk);
    fails++;
    conclude;
  end

  initial begin
    aresetn = 1'b0;
    lockout = 1'b0;
    mrn = 1'b1;
    margin_n = 1'b1;
    band = 1'b0;
    tsp = 1'b1;
    ext_done = 1'b0;
    wd_present = 1'b1;
    kick_en = 1'b0;
    drop = 8'h00;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    cyc(3);
    chk("rail_ok", 32'h0, {24'h0, rail_ok});
    chk("sys_reset_n", 32'h0, {31'h0, sys_reset_n});
    aresetn <= 1'b1;
    kick_en <= 1'b1;
    ex(1'b1, H, H + 40);
    chk("rail_ok", 32'hff, {24'h0, rail_ok});
    chk("adj_mv", 32'h18a, {22'h0, adj_mv});
    chk("wide", 32'h0, {31'h0, wide});
    band <= 1'b1;
    cyc(4);
    chk("adj_mv", 32'h175, {22'h0, adj_mv});
    chk("wide", 32'h1, {31'h0, wide});
    axr(mrrs_pkg::ADDR_STATUS);
    chk("status", 32'h000900ff, rd);
    axw(mrrs_pkg::ADDR_IRQ, 32'h7);
    axw(mrrs_pkg::ADDR_MASK, 32'h0);
    // A second drop during the hold must restart the full count
    drop <= 8'h08;
    ex(1'b0, 0, 8);
    cyc(2);
    chk("rail_ok", 32'hf7, {24'h0, rail_ok});
    drop <= 8'h00;
    cyc(20);
    drop <= 8'h80;
    cyc(4);
    drop <= 8'h00;
    ex(1'b1, H, H + 40);
    axr(mrrs_pkg::ADDR_IRQ);
    chk("irq_status", 32'h4, rd & 32'h4);
    chk("irq", 32'h0, {31'h0, irq});
    axw(mrrs_pkg::ADDR_MASK, 32'h4);
    axr(mrrs_pkg::ADDR_MASK);
    chk("mask", 32'h4, rd);
    cyc(2);
    chk("irq", 32'h1, {31'h0, irq});
    axw(mrrs_pkg::ADDR_IRQ, 32'h7);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    axr(12'h100);
    chk("rresp", {30'h0, mrrs_pkg::RESP_SLVERR}, {30'h0, rsp});
    axw(12'h104, 32'h0);
    chk("bresp", {30'h0, mrrs_pkg::RESP_SLVERR}, {30'h0, rsp});
    // Bouncing switch at press and at release
    mrn <= 1'b0;
    cyc(1);
    mrn <= 1'b1;
    cyc(1);
    mrn <= 1'b0;
    ex(1'b0, 0, 12);
    cyc(20);
    mrn <= 1'b1;
    cyc(1);
    mrn <= 1'b0;
    cyc(1);
    mrn <= 1'b1;
    ex(1'b1, H, H + 40);
    mrn <= 1'b0;
    cyc(2);
    mrn <= 1'b1;
    stay(12);
    kick_en <= 1'b0;
    ex(1'b0, W - 40, W + 20);
    kick_en <= 1'b1;
    ex(1'b1, H, H + 40);
    wd_present <= 1'b0;
    kick_en <= 1'b0;
    stay(W + 40);
    kick_en <= 1'b1;
    cyc(40);
    wd_present <= 1'b1;
    // Margin: outputs frozen high while the watchdog expires
    margin_n <= 1'b0;
    kick_en <= 1'b0;
    drop <= 8'hff;
    cyc(W + 30);
    chk("sys_reset_n", 32'h1, {31'h0, sys_reset_n});
    chk("rail_ok", 32'hff, {24'h0, rail_ok});
    drop <= 8'h00;
    // Let the inner sequence finish so only the watchdog can pull reset
    cyc(H + 20);
    chk("sys_reset_n", 32'h1, {31'h0, sys_reset_n});
    margin_n <= 1'b1;
    ex(1'b0, M, M + 12);
    kick_en <= 1'b1;
    ex(1'b1, H, H + 40);
    tsp <= 1'b0;
    mrn <= 1'b0;
    ex(1'b0, 0, 12);
    cyc(6);
    mrn <= 1'b1;
    wt(1'b1, H + 40);
    chk("sys_reset_n", 32'h0, {31'h0, sys_reset_n});
    ext_done <= 1'b1;
    ex(1'b1, 0, 12);
    tsp <= 1'b1;
    ext_done <= 1'b0;
    lockout <= 1'b1;
    drop <= 8'h10;
    ex(1'b0, 0, 8);
    cyc(2);
    chk("rail_ok", 32'h0, {24'h0, rail_ok});
    lockout <= 1'b0;
    cyc(8);
    chk("rail_ok", 32'hef, {24'h0, rail_ok});
    drop <= 8'h00;
    ex(1'b1, H, H + 40);
    conclude;
  end
endmodule // mrrs_top_tb_top
